/* File: logic/deg_guard.sv */
// register interface and write protection for the on-chip data eeprom
`default_nettype none

module deg_guard #(
    parameter int PUT_CYCLES   = deg_pkg::PUT_CYCLES,
    parameter int WRITE_CYCLES = deg_pkg::WRITE_CYCLES
) (
    // clock and resets
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  por,
    // configuration straps
    input  wire logic                  large_variant,
    input  wire logic                  delay_timer_enable,
    // register bus
    input  wire deg_pkg::deg_bus_req_t req,
    output logic                [7:0]  reg_rdata,
    // status
    input  wire logic                  write_done_clear,
    output logic                       write_done_flag,
    output logic                       write_busy,
    output logic                       power_up_delay_timer
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire logic hit_data    = req.addr == deg_pkg::ADDR_DATA;
    wire logic hit_address = req.addr == deg_pkg::ADDR_ADDRESS;
    wire logic hit_control = req.addr == deg_pkg::ADDR_CONTROL;
    wire logic hit_unlock  = req.addr == deg_pkg::ADDR_UNLOCK;

    // no code-protect term gates any of these strobes
    wire logic wr_data     = req.wr && hit_data;
    wire logic wr_address  = req.wr && hit_address;
    wire logic wr_control  = req.wr && hit_control;

    wire logic set_wr      = wr_control && req.wdata[deg_pkg::CTL_WR];
    wire logic set_rd      = wr_control && req.wdata[deg_pkg::CTL_RD];
    wire logic wdata_enable = req.wdata[deg_pkg::CTL_EN];
    wire logic wdata_abort  = req.wdata[deg_pkg::CTL_ABORT];

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]              data_reg;
    logic [7:0]              address_reg;
    logic                    write_enable_latch;
    logic                    read_start;
    logic                    write_abort_flag;
    logic                    write_in_flight;
    logic                    put_sampled;
    logic                    put_active;
    logic [deg_pkg::CNT_W-1:0] put_cnt;
    logic [deg_pkg::CNT_W-1:0] write_cnt;
    logic [7:0]              write_addr_hold;
    logic [7:0]              write_data_hold;

    // ------------------------------------------------------------------
    // unlock sequence
    // ------------------------------------------------------------------
    logic unlock_armed;

    deg_unlock u_unlock (
        .clk   (clk),
        .rst   (rst),
        .req   (req),
        .armed (unlock_armed)
    );

    // ------------------------------------------------------------------
    // array and address masking
    // ------------------------------------------------------------------
    wire logic [7:0] addr_mask = large_variant ? deg_pkg::ADDR_MASK_LARGE : deg_pkg::ADDR_MASK_SMALL;
    wire logic [7:0] array_rd_addr = address_reg & addr_mask;
    wire logic [7:0] array_wr_addr = write_addr_hold & addr_mask;
    logic [7:0]      array_rd_data;

    wire logic write_last = write_busy && write_cnt == deg_pkg::CNT_W'(WRITE_CYCLES - 1);

    deg_array u_array (
        .clk     (clk),
        .wr_en   (write_last),
        .wr_addr (array_wr_addr),
        .wr_data (write_data_hold),
        .rd_addr (array_rd_addr),
        .rd_data (array_rd_data)
    );

    // ------------------------------------------------------------------
    // write start qualification
    // ------------------------------------------------------------------
    // stored enable is used, so one write that sets both bits is refused unless enable was already set
    wire logic write_start = set_wr
                          && write_enable_latch
                          && unlock_armed
                          && !put_active
                          && !write_busy;

    // a read during a write would race the array update; it is ignored
    wire logic read_accept = set_rd && !write_busy && !read_start;

    // ------------------------------------------------------------------
    // power-up delay timer
    // ------------------------------------------------------------------
    // strap is caught on the first edge after power-on release
    always_ff @(posedge clk or posedge por) begin
        if (por) begin
            put_sampled <= 1'b0;
        end else begin
            put_sampled <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge por) begin
        if (por) begin
            put_active <= 1'b0;
        end else if (!put_sampled) begin
            put_active <= delay_timer_enable;
        end else if (put_active && put_cnt == deg_pkg::CNT_W'(PUT_CYCLES - 1)) begin
            put_active <= 1'b0;
        end
    end

    // never wraps: the gate drops before the counter could
    always_ff @(posedge clk or posedge por) begin
        if (por) begin
            put_cnt <= '0;
        end else if (put_active) begin
            put_cnt <= put_cnt + 1'b1;
        end
    end

    // the gate itself blocks starts; this visible copy lags it by one cycle
    always_ff @(posedge clk or posedge por) begin
        if (por) begin
            power_up_delay_timer <= 1'b0;
        end else begin
            power_up_delay_timer <= put_active;
        end
    end

    // ------------------------------------------------------------------
    // data and address registers
    // ------------------------------------------------------------------
    // only power-on clears these; other resets leave them for a retry
    always_ff @(posedge clk or posedge por) begin
        if (por) begin
            data_reg <= deg_pkg::DATA_POR_VALUE;
        end else if (read_start) begin
            data_reg <= array_rd_data;
        end else if (wr_data) begin
            data_reg <= req.wdata;
        end
    end

    always_ff @(posedge clk or posedge por) begin
        if (por) begin
            address_reg <= deg_pkg::ADDRESS_POR_VALUE;
        end else if (wr_address) begin
            address_reg <= req.wdata;
        end
    end

    // ------------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            write_enable_latch <= deg_pkg::CTL_BIT_RESET;
        end else if (wr_control) begin
            write_enable_latch <= wdata_enable;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            read_start <= deg_pkg::CTL_BIT_RESET;
        end else begin
            read_start <= read_accept;
        end
    end

    // ------------------------------------------------------------------
    // write engine
    // ------------------------------------------------------------------
    // clearing write enable does not touch a running write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            write_busy <= deg_pkg::CTL_BIT_RESET;
        end else if (write_start) begin
            write_busy <= 1'b1;
        end else if (write_last) begin
            write_busy <= 1'b0;
        end
    end

    // fixed count stands in for the cell program time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            write_cnt <= '0;
        end else if (write_start || write_last) begin
            write_cnt <= '0;
        end else if (write_busy) begin
            write_cnt <= write_cnt + 1'b1;
        end
    end

    // operands held so a careless rewrite mid-cycle cannot corrupt the byte
    always_ff @(posedge clk) begin
        if (write_start) begin
            write_addr_hold <= address_reg;
            write_data_hold <= data_reg;
        end
    end

    // ------------------------------------------------------------------
    // write-complete flag
    // ------------------------------------------------------------------
    // a completion in the same cycle as a clear wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            write_done_flag <= 1'b0;
        end else if (write_last) begin
            write_done_flag <= 1'b1;
        end else if (write_done_clear) begin
            write_done_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // interrupted-write detection
    // ------------------------------------------------------------------
    // survives the ordinary reset so its loss of the engine can be seen
    always_ff @(posedge clk or posedge por) begin
        if (por) begin
            write_in_flight <= 1'b0;
        end else if (write_start) begin
            write_in_flight <= 1'b1;
        end else if (write_last || !write_busy) begin
            write_in_flight <= 1'b0;
        end
    end

    wire logic write_cut = write_in_flight && !write_busy;

    always_ff @(posedge clk or posedge por) begin
        if (por) begin
            write_abort_flag <= deg_pkg::ABORT_POR_VALUE;
        end else if (write_cut) begin
            write_abort_flag <= 1'b1;
        end else if (wr_control) begin
            write_abort_flag <= wdata_abort;
        end
    end

    // ------------------------------------------------------------------
    // read-back mux
    // ------------------------------------------------------------------
    wire logic [7:0] control_view = {4'h0,
                                     write_abort_flag,
                                     write_enable_latch,
                                     write_busy,
                                     read_start};

    // unmapped addresses read zero and their writes are dropped
    wire logic [7:0] rd_mux = hit_data    ? data_reg    :
                              hit_address ? address_reg :
                              hit_control ? control_view :
                              hit_unlock  ? deg_pkg::READ_ZERO :
                                            deg_pkg::READ_ZERO;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= deg_pkg::READ_ZERO;
        end else if (req.rd) begin
            reg_rdata <= rd_mux;
        end
    end

endmodule : deg_guard

`default_nettype wire

/* File: logic/deg_pkg.sv */
// shared constants, register map and bus carrier for the data eeprom guard
`default_nettype none

package deg_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_DATA    = 8'h9A;
    localparam logic [7:0] ADDR_ADDRESS = 8'h9B;
    localparam logic [7:0] ADDR_CONTROL = 8'h9C;
    localparam logic [7:0] ADDR_UNLOCK  = 8'h9D;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int CTL_RD    = 0;
    localparam int CTL_WR    = 1;
    localparam int CTL_EN    = 2;
    localparam int CTL_ABORT = 3;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] DATA_POR_VALUE    = 8'h00;
    localparam logic [7:0] ADDRESS_POR_VALUE = 8'h00;
    localparam logic       CTL_BIT_RESET     = 1'b0;
    localparam logic       ABORT_POR_VALUE   = 1'b0;
    localparam logic [7:0] READ_ZERO         = 8'h00;

    // ------------------------------------------------------------------
    // unlock keys
    // ------------------------------------------------------------------
    localparam logic [7:0] UNLOCK_KEY_FIRST  = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;

    // ------------------------------------------------------------------
    // array size options
    // ------------------------------------------------------------------
    localparam int         ARRAY_DEPTH       = 256;
    localparam logic [7:0] ADDR_MASK_LARGE   = 8'hFF;
    localparam logic [7:0] ADDR_MASK_SMALL   = 8'h7F;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ          = 125_000_000;
    localparam int PUT_TIME_MS     = 72;
    localparam int PUT_CYCLES      = (CLK_HZ / 1000) * PUT_TIME_MS;
    localparam int WRITE_TIME_US   = 4000;
    localparam int WRITE_CYCLES    = (CLK_HZ / 1_000_000) * WRITE_TIME_US;
    localparam int CNT_W           = 24;

    // ------------------------------------------------------------------
    // register bus request from the cpu
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } deg_bus_req_t;

endpackage : deg_pkg

`default_nettype wire

/* File: logic/deg_array.sv */
// byte-wide nonvolatile array with asynchronous read and clocked write
`default_nettype none

module deg_array (
    // clock
    input  wire logic       clk,
    // write side
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_addr,
    input  wire logic [7:0] wr_data,
    // read side
    input  wire logic [7:0] rd_addr,
    output logic      [7:0] rd_data
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    // no reset: contents survive every reset, as an eeprom does
    logic [7:0] mem [0:deg_pkg::ARRAY_DEPTH-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];

endmodule : deg_array

`default_nettype wire

/* File: logic/deg_unlock.sv */
// tracker for the two-key unlock sequence ahead of a write start
`default_nettype none

module deg_unlock (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // observed bus traffic
    input  wire deg_pkg::deg_bus_req_t req,
    // sequence complete, next access may start a write
    output logic                       armed
);

    typedef enum logic [1:0] {
        DEG_IDLE,
        DEG_GOT_FIRST,
        DEG_ARMED
    } deg_unlock_state_t;

    deg_unlock_state_t state;
    deg_unlock_state_t next_state;

    wire logic hit_unlock = req.addr == deg_pkg::ADDR_UNLOCK;
    wire logic key_first  = req.wr && hit_unlock && req.wdata == deg_pkg::UNLOCK_KEY_FIRST;
    wire logic key_second = req.wr && hit_unlock && req.wdata == deg_pkg::UNLOCK_KEY_SECOND;
    wire logic any_access = req.wr || req.rd;

    // any access that is not the expected next step breaks the sequence
    always_comb begin
        next_state = state;
        if (any_access) begin
            case (state)
                DEG_IDLE:      next_state = key_first ? DEG_GOT_FIRST : DEG_IDLE;
                DEG_GOT_FIRST: next_state = key_second ? DEG_ARMED : (key_first ? DEG_GOT_FIRST : DEG_IDLE);
                DEG_ARMED:     next_state = key_first ? DEG_GOT_FIRST : DEG_IDLE;
                default:       next_state = DEG_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= DEG_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign armed = state == DEG_ARMED;

endmodule : deg_unlock

`default_nettype wire

/* File: verif/deg_guard_monitor.sv */
// concurrent checks on the data eeprom guard ports
`default_nettype none

module deg_guard_monitor #(
    parameter int PUT_CYCLES   = 16,
    parameter int WRITE_CYCLES = 20
) (
    // clock and resets
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  por,
    // bus and status
    input wire deg_pkg::deg_bus_req_t req,
    input wire logic [7:0]            reg_rdata,
    input wire logic                  write_done_clear,
    input wire logic                  write_done_flag,
    input wire logic                  write_busy,
    input wire logic                  power_up_delay_timer
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // helper state: unlock keys seen, stored enable, busy length
    // ------------------------------------------------------------------
    wire ctl_wr = req.wr && req.addr == deg_pkg::ADDR_CONTROL;
    wire key1   = req.wr && req.addr == deg_pkg::ADDR_UNLOCK && req.wdata == deg_pkg::UNLOCK_KEY_FIRST;
    wire key2   = req.wr && req.addr == deg_pkg::ADDR_UNLOCK && req.wdata == deg_pkg::UNLOCK_KEY_SECOND;
    logic seen1;
    logic seen2;
    logic en;
    int   busy_len;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seen1    <= 1'b0;
            seen2    <= 1'b0;
            en       <= 1'b0;
            busy_len <= 0;
        end else begin
            // any access, a read too, breaks the key chain
            if (req.wr || req.rd) begin
                seen1 <= key1;
                seen2 <= key2 && seen1;
            end
            if (ctl_wr) begin
                en <= req.wdata[deg_pkg::CTL_EN];
            end
            busy_len <= write_busy ? busy_len + 1 : 0;
        end
    end

    sequence s_start;
        ctl_wr && req.wdata[deg_pkg::CTL_WR];
    endsequence
    sequence s_armed;
        seen2 && en && !write_busy && !power_up_delay_timer;
    endsequence

    a_outs_in_reset: assert property (disable iff (por) rst |-> !write_busy && !write_done_flag && reg_rdata == 8'h00)
        else $error("outputs not cleared in reset");
    a_busy_from_start: assert property ($rose(write_busy) |-> $past(ctl_wr && req.wdata[deg_pkg::CTL_WR]))
        else $error("write began without a start request");
    a_start_keys: assert property ($rose(write_busy) |-> $past(seen2))
        else $error("write began without both keys");
    a_start_enable: assert property ($rose(write_busy) |-> $past(en))
        else $error("write began with enable clear");
    a_start_timer: assert property ($rose(write_busy) |-> !power_up_delay_timer)
        else $error("write began under power-up delay");
    a_start_taken: assert property (s_start ##0 s_armed |=> write_busy)
        else $error("valid start refused");
    a_write_length: assert property ($fell(write_busy) |-> busy_len == WRITE_CYCLES)
        else $error("write time wrong");
    a_done_at_end: assert property ($fell(write_busy) |-> write_done_flag)
        else $error("done flag missing at write end");
    a_done_sticky: assert property (write_done_flag && !write_done_clear |=> write_done_flag)
        else $error("done flag lost");
    a_unlock_reads_zero: assert property (req.rd && req.addr == deg_pkg::ADDR_UNLOCK |=> reg_rdata == 8'h00)
        else $error("unlock register read not zero");
    a_ctl_upper_zero: assert property (req.rd && req.addr == deg_pkg::ADDR_CONTROL |=> reg_rdata[7:4] == 4'h0)
        else $error("control upper bits not zero");
    a_rdata_holds: assert property (!req.rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
endmodule : deg_guard_monitor

bind deg_guard deg_guard_monitor #(
    .PUT_CYCLES  (PUT_CYCLES),
    .WRITE_CYCLES(WRITE_CYCLES)
) u_deg_guard_monitor (
    .clk                 (clk),
    .rst                 (rst),
    .por                 (por),
    .req                 (req),
    .reg_rdata           (reg_rdata),
    .write_done_clear    (write_done_clear),
    .write_done_flag     (write_done_flag),
    .write_busy          (write_busy),
    .power_up_delay_timer(power_up_delay_timer)
);

`default_nettype wire

/* File: verif/deg_guard_bench.sv */
// self-checking bench for the data eeprom guard
`default_nettype none

module deg_guard_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // short counts keep the run brief
    localparam int PUT_N = 40;
    localparam int WR_N  = 20;

    typedef struct {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } deg_row_t;

    logic                  clk              = 1'b0;
    logic                  rst              = 1'b1;
    logic                  por              = 1'b1;
    logic                  large_variant    = 1'b0;
    logic                  delay_timer_enable = 1'b1;
    deg_pkg::deg_bus_req_t req              = '0;
    logic                  write_done_clear = 1'b0;
    logic [7:0]            reg_rdata;
    logic                  write_done_flag;
    logic                  write_busy;
    logic                  power_up_delay_timer;
    int                    failures         = 0;
    int                    cmp_count        = 0;
    logic [7:0]            got;
    deg_row_t              rows [6];

    always #4 clk = ~clk;

    deg_guard #(
        .PUT_CYCLES  (PUT_N),
        .WRITE_CYCLES(WR_N)
    ) DUT (
        .clk                 (clk),
        .rst                 (rst),
        .por                 (por),
        .large_variant       (large_variant),
        .delay_timer_enable  (delay_timer_enable),
        .req                 (req),
        .reg_rdata           (reg_rdata),
        .write_done_clear    (write_done_clear),
        .write_done_flag     (write_done_flag),
        .write_busy          (write_busy),
        .power_up_delay_timer(power_up_delay_timer)
    );

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [7:0] act, input logic [7:0] exp, input string what);
        cmp_count++;
        if (act !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, act, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1;
        d = reg_rdata;
    endtask : rd_reg

    task automatic do_reset(input logic p, input logic lg, input logic pe);
        rst           <= 1'b1;
        por           <= p;
        large_variant <= lg;
        delay_timer_enable <= pe;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
    endtask : do_reset

    task automatic unlock_start();
        wr_reg(deg_pkg::ADDR_CONTROL, 8'h04);
        wr_reg(deg_pkg::ADDR_UNLOCK, deg_pkg::UNLOCK_KEY_FIRST);
        wr_reg(deg_pkg::ADDR_UNLOCK, deg_pkg::UNLOCK_KEY_SECOND);
        wr_reg(deg_pkg::ADDR_CONTROL, 8'h06);
        #1;
    endtask : unlock_start

    task automatic start_write(input logic [7:0] a, input logic [7:0] d);
        wr_reg(deg_pkg::ADDR_DATA, d);
        wr_reg(deg_pkg::ADDR_ADDRESS, a);
        unlock_start();
    endtask : start_write

    task automatic wait_idle();
        int n;
        n = 0;
        while (write_busy !== 1'b0 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (write_busy !== 1'b0) begin
            failures++;
            summarize();
        end
    endtask : wait_idle

    task automatic read_byte(input logic [7:0] a, input logic [7:0] exp);
        wr_reg(deg_pkg::ADDR_ADDRESS, a);
        wr_reg(deg_pkg::ADDR_CONTROL, 8'h01);
        rd_reg(deg_pkg::ADDR_DATA, got);
        check(got, exp, "array byte");
    endtask : read_byte

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rows = '{'{deg_pkg::ADDR_CONTROL, 8'h00, 8'h00}, '{deg_pkg::ADDR_DATA, 8'hC3, 8'hC3},
                 '{deg_pkg::ADDR_ADDRESS, 8'h7E, 8'h7E}, '{deg_pkg::ADDR_UNLOCK, 8'h55, 8'h00},
                 '{8'h40, 8'hFF, 8'h00}, '{deg_pkg::ADDR_CONTROL, 8'h08, 8'h08}};
        do_reset(1'b1, 1'b0, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        check(8'(power_up_delay_timer), 8'h01, "timer running");
        rd_reg(deg_pkg::ADDR_CONTROL, got);
        check(got, 8'h00, "control after power-up");
        start_write(8'h05, 8'h11);
        check(8'(write_busy), 8'h00, "start under timer");
        foreach (rows[i]) begin
            wr_reg(rows[i].addr, rows[i].wdata);
            rd_reg(rows[i].addr, got);
            check(got, rows[i].exp, "register row");
        end
        wr_reg(deg_pkg::ADDR_CONTROL, 8'h00);
        for (int i = 0; i < 100 && power_up_delay_timer !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        check(8'(power_up_delay_timer), 8'h00, "timer expired");
        if (power_up_delay_timer !== 1'b0) begin
            summarize();
        end
        // enable clear: keys then start must be refused
        wr_reg(deg_pkg::ADDR_UNLOCK, deg_pkg::UNLOCK_KEY_FIRST);
        wr_reg(deg_pkg::ADDR_UNLOCK, deg_pkg::UNLOCK_KEY_SECOND);
        wr_reg(deg_pkg::ADDR_CONTROL, 8'h06);
        #1;
        check(8'(write_busy), 8'h00, "start without enable");
        // a read between the keys breaks the chain
        wr_reg(deg_pkg::ADDR_CONTROL, 8'h04);
        wr_reg(deg_pkg::ADDR_UNLOCK, deg_pkg::UNLOCK_KEY_FIRST);
        rd_reg(deg_pkg::ADDR_DATA, got);
        wr_reg(deg_pkg::ADDR_UNLOCK, deg_pkg::UNLOCK_KEY_SECOND);
        wr_reg(deg_pkg::ADDR_CONTROL, 8'h06);
        #1;
        check(8'(write_busy), 8'h00, "broken key chain");
        start_write(8'h85, 8'h3C);
        check(8'(write_busy), 8'h01, "valid start");
        wr_reg(deg_pkg::ADDR_CONTROL, 8'h00);
        wait_idle();
        check(8'(write_done_flag), 8'h01, "done after disabled enable");
        rd_reg(deg_pkg::ADDR_CONTROL, got);
        check(got, 8'h00, "write bit cleared");
        @(posedge clk);
        write_done_clear <= 1'b1;
        @(posedge clk);
        write_done_clear <= 1'b0;
        #1;
        check(8'(write_done_flag), 8'h00, "done flag cleared");
        read_byte(8'h05, 8'h3C);
        @(posedge clk);
        do_reset(1'b1, 1'b1, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        check(8'(power_up_delay_timer), 8'h00, "timer disabled");
        start_write(8'h85, 8'h5A);
        check(8'(write_busy), 8'h01, "start with timer off");
        wait_idle();
        read_byte(8'h85, 8'h5A);
        read_byte(8'h05, 8'h3C);
        @(posedge clk);
        do_reset(1'b0, 1'b1, 1'b0);
        rd_reg(deg_pkg::ADDR_DATA, got);
        check(got, 8'h3C, "data kept over reset");
        rd_reg(deg_pkg::ADDR_ADDRESS, got);
        check(got, 8'h05, "address kept over reset");
        // reset cutting a running write leaves the abort flag
        start_write(8'h10, 8'h77);
        repeat (3) @(posedge clk);
        do_reset(1'b0, 1'b1, 1'b0);
        rd_reg(deg_pkg::ADDR_CONTROL, got);
        check(got, 8'h08, "abort flag after cut write");
        // refresh walks the whole array; every rewrite must start and land
        for (int a = 0; a < 256; a++) begin
            wr_reg(deg_pkg::ADDR_ADDRESS, 8'(a));
            wr_reg(deg_pkg::ADDR_CONTROL, 8'h01);
            unlock_start();
            check(8'(write_busy), 8'h01, "refresh start");
            wait_idle();
        end
        read_byte(8'h05, 8'h3C);
        read_byte(8'h85, 8'h5A);
        summarize();
    end
endmodule : deg_guard_bench

`default_nettype wire
